// >>> pwa_regs.vh
// Function
// - Ack each byte, step pointer, keep page
// - Pointer wraps to location 0 same page
// - Four bytes leave pointer at start location
// - Extra bytes overwrite earlier ones in turn
// - Configuration region is 22 four-byte pages
// - Operations region layout from 0x80 onward
// - Stop after write starts ignored write cycle
// - Withhold acknowledge for protected addresses
`ifndef PWA_REGS_VH
`define PWA_REGS_VH

// Seven-bit bus address; low bit follows the address strap
`define PWA_DEV_BASE      7'h28
// Address map
`define PWA_CFG_LAST      8'h57
`define PWA_RSV_LAST      8'h7f
`define PWA_OPS_FIRST     8'h80
`define PWA_STATUS_LAST   8'h83
`define PWA_BALANCE       8'h84
`define PWA_ANALOG_OUT    8'h85
`define PWA_SWITCH_CTL    8'h86
`define PWA_OVERRIDE      8'h87
`define PWA_FORCE_OPS     8'h88
`define PWA_NV_GATE       8'h89
`define PWA_ADDR_LAST     8'hab
`define PWA_NV_GATE_BIT   0
// Page layout: low two address bits select the byte within a page
`define PWA_PAGE_BITS     2
`define PWA_PAGE_STEP     2'h1
// Internal write cycle after a stop, in ns, and clock rate in MHz
`define PWA_WR_CYCLE_NS   1000
`define PWA_CLK_MHZ       10
`define PWA_BYTE_BITS     4'h8

`endif

// >>> pwa_page_write.v
`timescale 1ns/1ns
`default_nettype none
`include "pwa_regs.vh"

module pwa_page_write #(
  parameter WR_CYCLE_NS = `PWA_WR_CYCLE_NS,
  parameter MEM_DEPTH   = 172
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       scl,
  input  wire       sda_in,
  input  wire       addr_sel,
  output reg        sda_out,
  output reg        sda_oe,
  output reg  [7:0] power_switch_control,
  output reg        nonvolatile_write_gate,
  output reg        write_busy
);

  // Least time rounds up to whole cycles, never below one
  localparam WR_CYC_RAW = (WR_CYCLE_NS * `PWA_CLK_MHZ + 999) / 1000;
  localparam WR_CYC     = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_DEV   = 3'h1;
  localparam [2:0] ST_REG   = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_RDATA = 3'h4;
  localparam [2:0] ST_BUSY  = 3'h5;

  reg  [7:0]  mem [0:MEM_DEPTH-1];
  reg  [2:0]  state;
  reg  [3:0]  cnt;
  reg         ack_phase;
  reg         ack_given;
  reg         rw;
  reg         wrote;
  reg  [7:0]  shreg;
  reg  [7:0]  ptr;
  reg  [31:0] busy_cnt;
  reg         scl_q;
  reg         sda_q;
  reg         dev_strap;

  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_c  = scl & scl_q & sda_q & ~sda_in;
  wire stop_c   = scl & scl_q & ~sda_q & sda_in;
  wire dev_match = (shreg[7:1] == (`PWA_DEV_BASE | {6'h00, dev_strap}));

  // On writes the pointer steps inside its page only; reads step on across pages
  wire [7:0] page_next = {ptr[7:`PWA_PAGE_BITS],
                          ptr[`PWA_PAGE_BITS-1:0] + `PWA_PAGE_STEP};

  // Status and measurement bytes are read-only, reserved space is protected
  wire writable = (ptr <= `PWA_CFG_LAST) ||
                  ((ptr >= `PWA_BALANCE) && (ptr <= `PWA_NV_GATE));

  reg [7:0] rd_byte;
  always @* begin
    if (ptr == `PWA_SWITCH_CTL)
      rd_byte = power_switch_control;
    else if (ptr == `PWA_NV_GATE)
      rd_byte = {7'h00, nonvolatile_write_gate};
    else if (ptr <= `PWA_ADDR_LAST)
      rd_byte = mem[ptr];
    else
      rd_byte = 8'h00;
  end

  // Array has no reset; it stands in for the backed configuration store
  always @(posedge clk) begin
    if ((state == ST_WDATA) && scl_fall && !ack_phase &&
        (cnt == `PWA_BYTE_BITS) && writable)
      mem[ptr] <= shreg;
  end

  // Strap is taken by the clock, never by the reset itself
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_strap <= 1'b0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
    end else begin
      dev_strap <= addr_sel;
      scl_q     <= scl;
      sda_q     <= sda_in;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state                  <= ST_IDLE;
      cnt                    <= 4'h0;
      ack_phase              <= 1'b0;
      ack_given              <= 1'b0;
      rw                     <= 1'b0;
      wrote                  <= 1'b0;
      shreg                  <= 8'h00;
      ptr                    <= 8'h00;
      busy_cnt               <= 32'h0;
      sda_out                <= 1'b1;
      sda_oe                 <= 1'b0;
      power_switch_control   <= 8'h00;
      nonvolatile_write_gate <= 1'b0;
      write_busy             <= 1'b0;
    end else if (state == ST_BUSY) begin
      // Bus is ignored and data line released until the cycle ends
      sda_oe <= 1'b0;
      if (busy_cnt >= WR_CYC - 1) begin
        state      <= ST_IDLE;
        write_busy <= 1'b0;
        busy_cnt   <= 32'h0;
      end else begin
        busy_cnt <= busy_cnt + 32'h1;
      end
    end else if (start_c) begin
      state     <= ST_DEV;
      cnt       <= 4'h0;
      ack_phase <= 1'b0;
      wrote     <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (stop_c) begin
      sda_oe <= 1'b0;
      if (wrote) begin
        state      <= ST_BUSY;
        write_busy <= 1'b1;
        busy_cnt   <= 32'h0;
      end else begin
        state <= ST_IDLE;
      end
      wrote <= 1'b0;
    end else begin
      case (state)
        ST_DEV, ST_REG, ST_WDATA: begin
          if (scl_rise && !ack_phase) begin
            shreg <= {shreg[6:0], sda_in};
            cnt   <= cnt + 4'h1;
          end else if (scl_fall && ack_phase) begin
            // End of the acknowledge slot
            ack_phase <= 1'b0;
            cnt       <= 4'h0;
            if (!ack_given) begin
              sda_oe <= 1'b0;
              state  <= ST_IDLE;
            end else if (state == ST_DEV && rw) begin
              state   <= ST_RDATA;
              sda_out <= rd_byte[7];
              sda_oe  <= 1'b1;
              shreg   <= {rd_byte[6:0], 1'b0};
              ptr     <= ptr + 8'h01;
            end else begin
              sda_oe <= 1'b0;
              if (state == ST_DEV)
                state <= ST_REG;
              else
                state <= ST_WDATA;
            end
          end else if (scl_fall && cnt == `PWA_BYTE_BITS) begin
            ack_phase <= 1'b1;
            sda_out   <= 1'b0;
            case (state)
              ST_DEV: begin
                rw        <= shreg[0];
                ack_given <= dev_match;
                sda_oe    <= dev_match;
              end
              ST_REG: begin
                ptr       <= shreg;
                ack_given <= 1'b1;
                sda_oe    <= 1'b1;
              end
              default: begin
                ack_given <= writable;
                sda_oe    <= writable;
                if (writable) begin
                  wrote <= 1'b1;
                  ptr   <= page_next;
                  if (ptr == `PWA_SWITCH_CTL)
                    power_switch_control <= shreg;
                  if (ptr == `PWA_NV_GATE)
                    nonvolatile_write_gate <= shreg[`PWA_NV_GATE_BIT];
                end
              end
            endcase
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            if (cnt == `PWA_BYTE_BITS) begin
              // Ninth clock: master acknowledge asks for another byte
              cnt <= 4'h0;
              if (sda_in) begin
                state <= ST_IDLE;
              end else begin
                shreg <= rd_byte;
                ptr   <= ptr + 8'h01;
              end
            end else begin
              cnt <= cnt + 4'h1;
            end
          end else if (scl_fall) begin
            if (cnt == `PWA_BYTE_BITS) begin
              sda_oe <= 1'b0;
            end else begin
              sda_out <= shreg[7];
              sda_oe  <= 1'b1;
              shreg   <= {shreg[6:0], 1'b0};
            end
          end
        end
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> pwa_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pwa_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       scl,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] power_switch_control,
  input wire logic       nonvolatile_write_gate,
  input wire logic       write_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ack; sda_oe && !sda_out; endsequence
  sequence s_busy; write_busy [*8]; endsequence
  property p_store; $changed(power_switch_control) |-> s_ack; endproperty
  property p_gate; $changed(nonvolatile_write_gate) |-> s_ack; endproperty
  property p_busy; $rose(write_busy) |-> s_busy; endproperty
  property p_quiet; write_busy |-> !sda_oe; endproperty
  // Ten clocks at the default write cycle length
  property p_len;
    $fell(write_busy) |-> $past(write_busy, 10) && !$past(write_busy, 11);
  endproperty
  property p_oe; $changed(sda_oe) |-> !scl; endproperty
  property p_idle; $changed(power_switch_control) |-> !write_busy; endproperty
  property p_once;
    $changed(power_switch_control) |=> $stable(power_switch_control) [*8];
  endproperty
  a_store: assert property (p_store) else $error("store no ack");
  a_gate: assert property (p_gate) else $error("gate no ack");
  a_busy: assert property (p_busy) else $error("busy short");
  a_quiet: assert property (p_quiet) else $error("drive in busy");
  a_len: assert property (p_len) else $error("busy length");
  a_oe: assert property (p_oe) else $error("sda moved, scl high");
  a_idle: assert property (p_idle) else $error("store in busy");
  a_once: assert property (p_once) else $error("double store");
endmodule
bind pwa_page_write pwa_monitor u_mon (.clk(clk), .rst_n(rst_n), .scl(scl),
  .sda_out(sda_out), .sda_oe(sda_oe),
  .power_switch_control(power_switch_control),
  .nonvolatile_write_gate(nonvolatile_write_gate), .write_busy(write_busy));
`default_nettype wire

// >>> pwa_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module pwa_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task ph;
    begin
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task start;
    begin
      sda_m = 1'b1;
      ph;
      scl = 1'b1;
      ph;
      sda_m = 1'b0;
      ph;
      scl = 1'b0;
      ph;
    end
  endtask
  task stop;
    begin
      sda_m = 1'b0;
      ph;
      scl = 1'b1;
      ph;
      sda_m = 1'b1;
      ph;
    end
  endtask
  // Any number of bytes may follow; the bench decides when to stop
  task wbyte(input logic [7:0] b, output logic ack);
    begin
      for (int i = 7; i >= 0; i--) begin
        sda_m = b[i];
        ph;
        scl = 1'b1;
        ph;
        scl = 1'b0;
        ph;
      end
      sda_m = 1'b1;
      ph;
      scl = 1'b1;
      ph;
      ack = !sda;
      scl = 1'b0;
      ph;
    end
  endtask
  // Bits are taken while the clock is high; last byte ends with no ack
  task rbyte(input logic last, output logic [7:0] b);
    begin
      for (int i = 7; i >= 0; i--) begin
        scl = 1'b1;
        ph;
        b[i] = sda;
        scl = 1'b0;
        ph;
      end
      sda_m = last;
      ph;
      scl = 1'b1;
      ph;
      scl = 1'b0;
      ph;
      sda_m = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// >>> pwa_page_write_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pwa_page_write_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       addr_sel = 1'b0;
  logic       ack;
  wire        scl;
  wire        sda_m;
  wire        sda_out;
  wire        sda_oe;
  wire  [7:0] power_switch_control;
  wire        gate;
  wire        write_busy;
  wire        sda = sda_m & ~(sda_oe & ~sda_out);
  int         n_fail = 0;
  int         total_checks = 0;
  always #50 clk = ~clk;
  pwa_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  pwa_page_write uut (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .addr_sel(addr_sel), .sda_out(sda_out), .sda_oe(sda_oe),
    .power_switch_control(power_switch_control),
    .nonvolatile_write_gate(gate), .write_busy(write_busy));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        n_fail++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      if (n_fail == 0 && total_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Five bytes from page location 2 of the 0x84 page: wrap, then overwrite
  task t_page;
    begin
      m.start;
      m.wbyte(8'h50, ack);
      m.wbyte(8'h86, ack);
      for (int i = 0; i < 5; i++) begin
        m.wbyte(8'h10 + i[7:0], ack);
        chk({7'h0, ack}, 8'h01);
        chk(power_switch_control, i == 4 ? 8'h14 : 8'h10);
      end
      m.stop;
      chk({7'h0, write_busy}, 8'h01);
      repeat (12) @(posedge clk);
      #1;
      chk({7'h0, write_busy}, 8'h00);
    end
  endtask
  // Read the 0x84 page back: wrap and overwrite leave 12 13 14 11
  task t_read;
    logic [7:0] b;
    begin
      m.start;
      m.wbyte(8'h50, ack);
      m.wbyte(8'h84, ack);
      m.start;
      m.wbyte(8'h51, ack);
      chk({7'h0, ack}, 8'h01);
      m.rbyte(1'b0, b);
      chk(b, 8'h12);
      m.rbyte(1'b0, b);
      chk(b, 8'h13);
      m.rbyte(1'b0, b);
      chk(b, 8'h14);
      m.rbyte(1'b1, b);
      chk(b, 8'h11);
      m.stop;
    end
  endtask
  task t_protect;
    begin
      m.start;
      m.wbyte(8'h50, ack);
      m.wbyte(8'h80, ack);
      m.wbyte(8'h77, ack);
      chk({7'h0, ack}, 8'h00);
      m.stop;
      chk({7'h0, write_busy}, 8'h00);
    end
  endtask
  // Single byte only: page writes stay out of the nonvolatile space
  task t_gate;
    begin
      addr_sel = 1'b1;
      m.start;
      m.wbyte(8'h52, ack);
      m.wbyte(8'h89, ack);
      m.wbyte(8'h01, ack);
      chk({7'h0, gate}, 8'h01);
      chk(power_switch_control, 8'h14);
      m.stop;
      repeat (12) @(posedge clk);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    t_page;
    t_read;
    t_protect;
    t_gate;
    print_verdict;
  end
  initial begin
    #3000000;
    n_fail++;
    print_verdict;
  end
endmodule
`default_nettype wire
